/* hw/bus_driver.sv */
// Processor-side end: issues bus cycles and waits for the transfer acknowledge
`include "mapper_defs.svh"
module bus_driver
  import mapper_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // User request
  input wire logic req_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`FC_W-1:0] fc_i,
  input wire logic wr_i,
  input wire logic user_i,
  input wire logic monitor_i,
  input wire logic target_ack_n_i,
  output logic busy_o,
  output logic done_o,
  output logic brk_o,
  // Link
  map_bus_if.cpu bus
);
  typedef enum logic [0:0] {
    IDLE = 1'b0,
    WAIT = 1'b1
  } drv_state_t;
  drv_state_t state_q;
  logic [`ADDR_W-1:0] addr_q;
  logic [`FC_W-1:0] fc_q;
  logic wr_q, user_q, mon_q, tack_q;

  // Cycle sequencer; holds the cycle until the acknowledge
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      state_q <= IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      brk_o <= 1'b0;
      addr_q <= '0;
      fc_q <= '0;
      wr_q <= 1'b0;
      user_q <= 1'b0;
      mon_q <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      brk_o <= bus.brk;
      case (state_q)
        IDLE:
        if (req_i)
        begin
          addr_q <= addr_i;
          fc_q <= fc_i;
          wr_q <= wr_i;
          user_q <= user_i;
          mon_q <= monitor_i;
          busy_o <= 1'b1;
          state_q <= WAIT;
        end
        WAIT:
        if (!bus.transfer_ack_n_o && bus.transfer_ack_oe)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Target acknowledge, supplied also for monitor cycles [RULE_09]
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      tack_q <= 1'b1;
    else
      tack_q <= target_ack_n_i;
  end

  assign bus.cyc = (state_q == WAIT);
  assign bus.addr = addr_q;
  assign bus.fc = fc_q;
  assign bus.wr = wr_q;
  assign bus.user = user_q;
  assign bus.monitor = mon_q;
  assign bus.target_ack_n = tack_q;
endmodule : bus_driver

/* hw/emulation_memory_mapper.sv */
// Emulation memory mapper: term compare, memory routing, acknowledge and breaks
//
// How it works
// RULE_01: Eight start/end terms, all compared each cycle.
// RULE_02: Emulation memory allocated in 512/1024-byte blocks.
// RULE_03: Overlapping terms separated by function code.
// RULE_04: Each term has one of five types.
// RULE_05: ROM access breaks when break-on-ROM enabled; the code breaks on user cycles only.
// RULE_06: Writes to emulation ROM still update memory.
// RULE_07: Unmatched cycles use the default type.
// RULE_08: Interlocked terms use only target acknowledge.
// RULE_09: Target acknowledges monitor cycles under interlock.
// RULE_10: Without interlock, mapper acknowledges emulation/monitor cycles.
// RULE_11: Dual-port terms go to 8-Kbyte blocks.
// RULE_12: Other terms go to plug-in modules.
// RULE_13: Software maps on-chip space as target RAM.
// RULE_14: Vector base/control words mapped RAM, register-accessed.
// RULE_15: Only map-interlock mode consults term interlock.
// RULE_16: Drive-high option actively deasserts own acknowledge.
// RULE_17: Match is inclusive range plus optional code.
// RULE_18: Guarded user access breaks and records address.
// RULE_19: Target types to target, emulation types local.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "mapper_defs.svh"
module emulation_memory_mapper
  import mapper_pkg::*;
#(
  parameter int TERMS = `MAP_TERMS
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt
  output logic irq_o,
  // Processor bus link
  map_bus_if.mapper bus
);
  // Refuse term counts outside 1 to 8, the reach of the 3-bit dual-port block index
  if (TERMS < 1 || TERMS > 8)
  begin : g_bad_terms
    $error("TERMS must be 1 to 8");
  end

  logic [`ADDR_W-1:0] start_q [TERMS];
  logic [`ADDR_W-1:0] end_q [TERMS];
  logic [10:0] attr_q [TERMS];
  logic [31:0] ctrl_q;
  logic [2:0] default_q;
  logic [1:0] status_q, mask_q;
  logic [`ADDR_W-1:0] brk_addr_q;
  logic [TERMS-1:0] hit;
  logic wr_acc, rd_acc, cyc_q, ack_pend_q;
  logic [1:0] wait_q;
  logic [3:0] hi_cnt_q;

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && !penable_i && !pwrite_i;

  // Every term compared in parallel [RULE_01]
  genvar g;
  generate
    for (g = 0; g < TERMS; g++)
    begin : g_term
      assign hit[g] = attr_q[g][`ATTR_VALID_BIT]
        && bus.addr >= start_q[g] && bus.addr <= end_q[g] // [RULE_17]
        && (!attr_q[g][`ATTR_FC_EN_BIT] || bus.fc == attr_q[g][`ATTR_FC_LSB +: 3]); // [RULE_03]
    end
  endgenerate

  // Lowest-numbered hit wins; unmatched falls to default
  mem_type_t mtype;
  logic ilk, dp;
  logic [3:0] idx;
  always_comb
  begin
    mtype = mem_type_t'(default_q); // [RULE_07]
    ilk = 1'b0;
    dp = 1'b0;
    idx = 4'h0;
    for (int i = TERMS - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        mtype = mem_type_t'(attr_q[i][`ATTR_TYPE_LSB +: 3]); // [RULE_04]
        ilk = attr_q[i][`ATTR_ILK_BIT];
        dp = attr_q[i][`ATTR_DP_BIT];
        idx = 4'(i);
      end
    end
  end

  logic is_emul, is_rom, own_ack, cyc_new;
  ack_mode_t amode;
  assign amode = ack_mode_t'(ctrl_q[`CTRL_ACK_MODE_LSB +: 2]);
  assign is_emul = (mtype == MEM_ERAM) || (mtype == MEM_EROM); // [RULE_19]
  assign is_rom = (mtype == MEM_EROM) || (mtype == MEM_TROM);
  assign cyc_new = bus.cyc && !cyc_q;
  // Mapper acknowledges only when mode and interlock allow [RULE_15]
  always_comb
  begin
    case (amode)
      ACK_MAP: own_ack = !ilk && (is_emul || bus.monitor); // [RULE_08] [RULE_10]
      ACK_TARGET: own_ack = 1'b0;
      default: own_ack = 1'b1;
    endcase
  end

  // Routing outputs, registered per cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      bus.sel_emul <= 1'b0;
      bus.emul_we <= 1'b0;
      bus.dual_port <= 1'b0;
      bus.dp_block <= 3'h0;
      cyc_q <= 1'b0;
    end
    else
    begin
      cyc_q <= bus.cyc;
      bus.sel_emul <= bus.cyc && is_emul; // [RULE_19]
      bus.emul_we <= bus.cyc && is_emul && bus.wr; // ROM type does not block array write [RULE_06]
      // Gated like the select so a held address leaves no stale dual-port level
      bus.dual_port <= bus.cyc && is_emul && dp; // [RULE_11] [RULE_12]
      // Block index from the term number: one 8-Kbyte block per term
      bus.dp_block <= idx[2:0]; // [RULE_11]
    end
  end

  // Acknowledge generation with optional active drive-high
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ack_pend_q <= 1'b0;
      wait_q <= 2'h0;
      hi_cnt_q <= 4'h0;
      bus.transfer_ack_n_o <= 1'b1;
      bus.transfer_ack_oe <= 1'b0;
    end
    else
    begin
      bus.transfer_ack_n_o <= 1'b1;
      bus.transfer_ack_oe <= 1'b0;
      if (cyc_new && own_ack)
      begin
        ack_pend_q <= 1'b1;
        wait_q <= (amode == ACK_EMUL1) ? 2'h1 : 2'h0;
      end
      else if (cyc_new && !bus.target_ack_n)
      begin
        // Target acknowledge passed through, never driven high by us [RULE_08]
        bus.transfer_ack_n_o <= 1'b0;
        bus.transfer_ack_oe <= 1'b1;
      end
      else if (bus.cyc && !ack_pend_q && !own_ack && !bus.target_ack_n && bus.transfer_ack_n_o)
      begin
        // One pass per cycle; the processor still shows the cycle while it takes the ack
        bus.transfer_ack_n_o <= 1'b0;
        bus.transfer_ack_oe <= 1'b1;
      end
      else if (ack_pend_q && wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
      else if (ack_pend_q)
      begin
        ack_pend_q <= 1'b0;
        bus.transfer_ack_n_o <= 1'b0;
        bus.transfer_ack_oe <= 1'b1;
        hi_cnt_q <= ctrl_q[`CTRL_DRIVE_HIGH_BIT] ? 4'(`DRIVE_HIGH_CYC) : 4'h0;
      end
      else if (hi_cnt_q != 4'h0)
      begin
        // Actively deassert so the next cycle sees no stale acknowledge [RULE_16]
        hi_cnt_q <= hi_cnt_q - 4'h1;
        bus.transfer_ack_oe <= 1'b1;
      end
    end
  end

  // Break and sticky status; set wins over clear
  logic ev_guard, ev_rom;
  assign ev_guard = cyc_new && bus.user && (mtype == MEM_GUARD); // [RULE_18]
  assign ev_rom = cyc_new && bus.user && is_rom && ctrl_q[`CTRL_BRK_ROM_BIT]; // [RULE_05]
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      status_q <= 2'h0;
      brk_addr_q <= '0;
      bus.brk <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~((wr_acc && paddr_i == `OFF_STATUS) ? pwdata_i[1:0] : 2'h0))
        | {ev_rom, ev_guard};
      if (ev_guard || ev_rom)
        brk_addr_q <= bus.addr; // [RULE_18]
      bus.brk <= ev_guard || ev_rom;
      irq_o <= |(status_q & mask_q);
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= 32'h0000_0000;
      default_q <= 3'h2;
      mask_q <= 2'h0;
      for (int i = 0; i < TERMS; i++)
      begin
        start_q[i] <= '0;
        end_q[i] <= '0;
        attr_q[i] <= '0;
      end
    end
    else if (wr_acc)
    begin
      case (paddr_i)
        `OFF_CTRL: ctrl_q <= {27'h0, pwdata_i[4:0]};
        `OFF_MASK: mask_q <= pwdata_i[1:0];
        `OFF_DEFAULT: default_q <= pwdata_i[2:0]; // [RULE_07]
        default: ;
      endcase
      for (int i = 0; i < TERMS; i++)
      begin
        // Start/end snapped to the allocation block size [RULE_02]
        if (paddr_i == 12'(`OFF_TERM_BASE + i * `TERM_STRIDE))
          start_q[i] <= pwdata_i[`ADDR_W-1:0] & (ctrl_q[`CTRL_BIG_BOARD_BIT] ? 24'hFF_FC00 : 24'hFF_FE00);
        if (paddr_i == 12'(`OFF_TERM_BASE + i * `TERM_STRIDE + 4))
          end_q[i] <= pwdata_i[`ADDR_W-1:0] | (ctrl_q[`CTRL_BIG_BOARD_BIT] ? 24'h00_03FF : 24'h00_01FF);
        if (paddr_i == 12'(`OFF_TERM_BASE + i * `TERM_STRIDE + 8))
          attr_q[i] <= pwdata_i[10:0];
      end
    end
  end

  // APB read data latched in setup, one wait-free access phase
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      if (rd_acc)
      begin
        prdata_o <= 32'h0000_0000;
        case (paddr_i)
          `OFF_CTRL: prdata_o <= ctrl_q;
          `OFF_STATUS: prdata_o <= {30'h0, status_q};
          `OFF_MASK: prdata_o <= {30'h0, mask_q};
          `OFF_BREAK_ADDR: prdata_o <= {8'h0, brk_addr_q};
          `OFF_DEFAULT: prdata_o <= {29'h0, default_q};
          default: ;
        endcase
        for (int i = 0; i < TERMS; i++)
        begin
          if (paddr_i == 12'(`OFF_TERM_BASE + i * `TERM_STRIDE))
            prdata_o <= {8'h0, start_q[i]};
          if (paddr_i == 12'(`OFF_TERM_BASE + i * `TERM_STRIDE + 4))
            prdata_o <= {8'h0, end_q[i]};
          if (paddr_i == 12'(`OFF_TERM_BASE + i * `TERM_STRIDE + 8))
            prdata_o <= {21'h0, attr_q[i]};
        end
      end
    end
  end
endmodule : emulation_memory_mapper

/* hw/map_bus_if.sv */
// Processor bus link between mapper and its processor/target side
`include "mapper_defs.svh"
interface map_bus_if;
  logic cyc;
  logic [`ADDR_W-1:0] addr;
  logic [`FC_W-1:0] fc;
  logic wr;
  logic user;
  logic monitor;
  logic target_ack_n;
  logic transfer_ack_n_o;
  logic transfer_ack_oe;
  logic sel_emul;
  logic emul_we;
  logic dual_port;
  logic [2:0] dp_block;
  logic brk;
  modport mapper (input cyc, addr, fc, wr, user, monitor, target_ack_n,
                  output transfer_ack_n_o, transfer_ack_oe, sel_emul, emul_we, dual_port, dp_block, brk);
  modport cpu (output cyc, addr, fc, wr, user, monitor, target_ack_n,
               input transfer_ack_n_o, transfer_ack_oe, sel_emul, emul_we, dual_port, dp_block, brk);
endinterface : map_bus_if

/* hw/mapper_defs.svh */
// Constants of the emulation memory mapper
`ifndef MAPPER_DEFS_SVH
`define MAPPER_DEFS_SVH
`define MAP_TERMS 8
`define ADDR_W 24
`define FC_W 3
`define BLOCK_SMALL 512
`define BLOCK_LARGE 1024
`define DPRAM_BLOCK_BYTES 8192
`define CLK_PERIOD_NS 25
`define DRIVE_HIGH_MIN_NS 5
`define DRIVE_HIGH_MAX_NS 10
// Longest time rounds down, but never below one cycle
`define DRIVE_HIGH_CYC ((`DRIVE_HIGH_MAX_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`DRIVE_HIGH_MAX_NS / `CLK_PERIOD_NS))
// Register offsets (APB byte addresses)
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_MASK 12'h008
`define OFF_BREAK_ADDR 12'h00C
`define OFF_DEFAULT 12'h010
`define OFF_TERM_BASE 12'h040
`define TERM_STRIDE 12'h010
// Term word layout: +0 start, +4 end, +8 attributes
`define ATTR_TYPE_LSB 0
`define ATTR_FC_LSB 4
`define ATTR_FC_EN_BIT 7
`define ATTR_ILK_BIT 8
`define ATTR_DP_BIT 9
`define ATTR_VALID_BIT 10
// Control bits
`define CTRL_BRK_ROM_BIT 0
`define CTRL_DRIVE_HIGH_BIT 1
`define CTRL_ACK_MODE_LSB 2
`define CTRL_BIG_BOARD_BIT 4
// Status bits
`define ST_GUARD_BIT 0
`define ST_ROM_BIT 1
`endif

/* hw/mapper_pkg.sv */
// Types of the emulation memory mapper
package mapper_pkg;
  typedef enum logic [2:0] {
    MEM_ERAM = 3'h0,
    MEM_EROM = 3'h1,
    MEM_TRAM = 3'h2,
    MEM_TROM = 3'h3,
    MEM_GUARD = 3'h4
  } mem_type_t;
  typedef enum logic [1:0] {
    ACK_MAP = 2'h0,
    ACK_TARGET = 2'h1,
    ACK_EMUL0 = 2'h2,
    ACK_EMUL1 = 2'h3
  } ack_mode_t;
endpackage : mapper_pkg

/* tb/emulation_memory_mapper_monitor.sv */
// Checker of the processor bus link between the mapper and the bus driver
module emulation_memory_mapper_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Link signals
  input wire logic cyc,
  input wire logic wr,
  input wire logic user,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_oe,
  input wire logic sel_emul,
  input wire logic emul_we,
  input wire logic dual_port,
  input wire logic brk
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  // Own acknowledge, then the released or driven-high tail
  sequence own_ack_s;
    transfer_ack_oe && !transfer_ack_n_o;
  endsequence
  sequence tail_s;
    transfer_ack_n_o;
  endsequence
  ack_pulse_a: assert property (own_ack_s |=> tail_s)
    else $error("own ack longer than one cycle");
  ack_tail_a: assert property (transfer_ack_oe ##1 transfer_ack_oe |=> !transfer_ack_oe)
    else $error("ack pin driven too long");
  oe_start_a: assert property ($rose(transfer_ack_oe) |-> !transfer_ack_n_o)
    else $error("pin driven without ack");
  ack_early_a: assert property ($rose(cyc) |-> transfer_ack_n_o [*2])
    else $error("ack too early");
  cycle_end_a: assert property ($rose(cyc) |-> ##[2:40] !cyc)
    else $error("bus cycle never ended");
  brk_pulse_a: assert property (brk |=> !brk)
    else $error("break longer than one cycle");
  brk_user_a: assert property (brk |-> cyc && user)
    else $error("break outside a user cycle");
  we_route_a: assert property ($rose(emul_we) |-> sel_emul && wr)
    else $error("emulation write without select");
  dp_route_a: assert property (dual_port |-> sel_emul)
    else $error("dual port without emulation select");
endmodule : emulation_memory_mapper_monitor

/* tb/emulation_memory_mapper_tb.sv */
// Self-checking bench of the mapper facing its bus driver
`include "mapper_defs.svh"
module emulation_memory_mapper_tb
  import mapper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic req_i = 0, wr_i = 0, user_i = 0, monitor_i = 0, target_ack_n_i = 1;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [23:0] addr_i = 0;
  logic [2:0] fc_i = 0;
  logic pready_o, pslverr_o, irq_o, busy_o, done_o, brk_o;
  // Result of a bus cycle: ack latency, drive-high, block, dual, we, sel, brk
  logic [15:0] res;
  logic brk_seen;
  int err_count = 0, num_checks = 0, cycles = 0;
  int ack_ctl [5] = '{0, 8, 12, 4, 2};
  int ack_lat [5] = '{0, 3, 4, 0, 3};
  map_bus_if i_map_bus_if ();
  emulation_memory_mapper #(.TERMS(`MAP_TERMS)) i_emulation_memory_mapper (.clk_sys_i, .resetn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .bus(i_map_bus_if));
  bus_driver i_bus_driver (.clk_sys_i, .resetn_i, .req_i, .addr_i, .fc_i, .wr_i, .user_i, .monitor_i,
    .target_ack_n_i, .busy_o, .done_o, .brk_o, .bus(i_map_bus_if));
  emulation_memory_mapper_monitor i_mon (.clk_sys_i, .resetn_i, .cyc(i_map_bus_if.cyc), .wr(i_map_bus_if.wr),
    .user(i_map_bus_if.user), .transfer_ack_n_o(i_map_bus_if.transfer_ack_n_o),
    .transfer_ack_oe(i_map_bus_if.transfer_ack_oe), .sel_emul(i_map_bus_if.sel_emul),
    .emul_we(i_map_bus_if.emul_we), .dual_port(i_map_bus_if.dual_port), .brk(i_map_bus_if.brk));
  // Clock, 25 ns period
  initial
  begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task chk_bus(input logic [15:0] exp, input logic [15:0] m);
    chk_reg({16'h0, res & m}, {16'h0, exp});
  endtask : chk_bus
  // APB master; waits on pready since no fixed latency is assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  task wreg(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask : wreg
  task rreg(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk_reg(rd, exp);
  endtask : rreg
  task set_term(input logic [11:0] n, input logic [31:0] s, input logic [31:0] e, input logic [31:0] a);
    wreg(`OFF_TERM_BASE + `TERM_STRIDE * n, s);
    wreg(`OFF_TERM_BASE + `TERM_STRIDE * n + 12'h4, e);
    wreg(`OFF_TERM_BASE + `TERM_STRIDE * n + 12'h8, a);
  endtask : set_term
  // One bus cycle; routing is sampled mid-cycle because the select, write and dual-port levels drop back to zero when the cycle ends
  task bus_cyc(input logic [23:0] a, input logic [2:0] f, input logic w, input logic u, input logic m);
    int n;
    int k;
    n = 0;
    k = 0;
    res = 0;
    brk_seen = 0;
    @(posedge clk_sys_i);
    req_i <= 1;
    addr_i <= a;
    fc_i <= f;
    wr_i <= w;
    user_i <= u;
    monitor_i <= m;
    do
    begin
      @(posedge clk_sys_i);
      req_i <= 0;
      if (k > 0 || i_map_bus_if.cyc === 1'b1)
        k++;
      if (k == 8)
        target_ack_n_i <= 0;
      if (k == 3)
        res[6:1] = {i_map_bus_if.dp_block, i_map_bus_if.dual_port, i_map_bus_if.emul_we, i_map_bus_if.sel_emul};
      if (i_map_bus_if.brk === 1'b1)
        res[0] = 1;
      if (brk_o === 1'b1)
        brk_seen = 1;
      if (k > 1 && res[15:8] == k - 1)
        res[7] = i_map_bus_if.transfer_ack_oe && i_map_bus_if.transfer_ack_n_o;
      // Latency counts the mapper's own ack only; a target ack comes after k reaches 8
      if (res[15:8] == 0 && k < 8 && i_map_bus_if.transfer_ack_oe === 1'b1 && i_map_bus_if.transfer_ack_n_o === 1'b0)
        res[15:8] = 8'(k);
      n++;
    end
    while (done_o !== 1'b1 && n < 60);
    target_ack_n_i <= 1;
    chk_reg({30'h0, busy_o, done_o}, 32'h1);
    chk_reg({31'h0, brk_seen}, {31'h0, res[0]});
  endtask : bus_cyc
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1;
    rreg(`OFF_CTRL, 32'h0);
    rreg(`OFF_DEFAULT, 32'h2);
    rreg(12'h800, 32'h0);
    bus_cyc(24'h00_5000, 0, 1, 1, 0);
    chk_bus(16'h0, 16'hFF8E);
    wreg(`OFF_CTRL, 32'h1);
    for (int t = 0; t < 5; t++)
    begin
      set_term(0, 32'h1300, 32'h1FFF, 32'h400 | 32'(t));
      bus_cyc(24'h00_1200, 0, 1, 1, 0);
      chk_bus({(t < 2) ? 8'h3 : 8'h0, 5'h0, t < 2, t < 2, t[0] || t[2]}, (t == 4) ? 16'hF : 16'hFF0F);
    end
    rreg(`OFF_BREAK_ADDR, 32'h1200);
    rreg(`OFF_STATUS, 32'h3);
    chk_reg({31'h0, irq_o}, 32'h0);
    wreg(`OFF_MASK, 32'h1);
    rreg(`OFF_MASK, 32'h1);
    chk_reg({31'h0, irq_o}, 32'h1);
    wreg(`OFF_STATUS, 32'h1);
    rreg(`OFF_STATUS, 32'h2);
    chk_reg({31'h0, irq_o}, 32'h0);
    set_term(0, 32'h1300, 32'h1FFF, 32'h400);
    bus_cyc(24'h00_1000, 0, 0, 1, 0);
    chk_bus(16'h0, 16'h2);
    wreg(`OFF_CTRL, 32'h10);
    // Bounds snap when written, so the term is written again under the large block
    set_term(0, 32'h1300, 32'h1FFF, 32'h400);
    bus_cyc(24'h00_1000, 0, 0, 1, 0);
    chk_bus(16'h2, 16'h2);
    bus_cyc(24'h00_1FFF, 0, 0, 1, 0);
    chk_bus(16'h2, 16'h2);
    bus_cyc(24'h00_2000, 0, 0, 1, 0);
    chk_bus(16'h0, 16'h2);
    set_term(0, 32'h1000, 32'h1FFF, 32'h4A2);
    set_term(1, 32'h1000, 32'h1FFF, 32'h6D0);
    bus_cyc(24'h00_1800, 3'h5, 0, 1, 0);
    chk_bus(16'h031A, 16'hFFFF);
    bus_cyc(24'h00_1800, 3'h2, 1, 1, 0);
    chk_bus(16'h0, 16'hFF0E);
    set_term(1, 32'h0, 32'h0, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wreg(`OFF_CTRL, 32'(ack_ctl[i]));
      set_term(0, 32'h1000, 32'h1FFF, (i < 3) ? 32'h500 : 32'h400);
      bus_cyc(24'h00_1800, 0, 0, 1, 0);
      chk_bus({8'(ack_lat[i]), i == 4, 7'h02}, 16'hFFFF);
    end
    set_term(7, 32'h3000, 32'h31FF, 32'h400);
    bus_cyc(24'h00_3100, 0, 0, 1, 0);
    chk_bus(16'h2, 16'h2);
    // Vector words mapped as emulation RAM, reached only by monitor reads
    set_term(2, 32'h0, 32'h1FF, 32'h400);
    bus_cyc(24'h00_00F4, 0, 0, 0, 1);
    chk_bus(16'h0302, 16'hFF06);
    wreg(`OFF_DEFAULT, 32'h4);
    bus_cyc(24'h00_8000, 0, 0, 0, 1);
    chk_bus(16'h0380, 16'hFF81);
    bus_cyc(24'h00_8000, 0, 0, 1, 0);
    chk_bus(16'h1, 16'h1);
    wrap_up();
  end
endmodule : emulation_memory_mapper_tb
